// >>> tvr_regs.sv
// timer value, reload and capture/compare registers with apb access and interrupts
`timescale 1ns/1ps

// Summary of operation
// - low irq enable gates low overflow, compare
// - second output enable only on two-pin variant
// - reset clears count, reload, capture/compare
// - count register holds 16-bit present count
// - dual mode: count reads upper byte zero
// - dual mode: count upper byte writes ignored
// - count high byte register always accesses it
// - reload register holds 16-bit reload value
// - dual mode: reload upper byte masked, blocked
// - reload high byte register accesses upper
// - compare mode: register is compare value
// - capture event loads count into register, upper byte only in dual mode
// - dual mode: capcmp upper byte masked, blocked
// - capcmp high byte register accesses upper
// - dual select: zero single, one dual
// - low overflow flag only in dual mode
// - low compare flag only in dual mode
// - capcmp flag on match or capture
module tvr_regs #(
    parameter bit TWO_PINS = 1'b1
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // counting engine side
    input  wire logic        count_load_i,
    input  wire logic [15:0] count_next_i,
    input  wire logic        overflow_i,
    input  wire logic        low_overflow_i,
    input  wire logic        capture_event_i,
    output logic [15:0]      count_o,
    output logic [15:0]      reload_o,
    output logic [15:0]      capcmp_o,
    output logic             dual_byte_select_o,
    output logic             counter_sel_o,
    output logic [1:0]       edge_sel_o,
    output logic             polarity1_o,
    output logic             second_output_enable_o,
    output logic             low_irq_o,
    output logic             irq_o
);
    import tvr_pkg::*;

    logic [15:0]         count_ff;
    logic [15:0]         reload_ff;
    logic [15:0]         capcmp_ff;
    logic [7:0]          ctrl_b_ff;
    logic [3:0]          cfg_ff;
    logic [IRQ_BITS-1:0] irq_sts_ff;
    logic [IRQ_BITS-1:0] irq_en_ff;
    logic [31:0]         prdata_ff;
    logic [31:0]         nxt_prdata;
    logic                nxt_slverr;
    logic [5:0]          idx;
    logic                aligned;
    logic                mapped;
    logic                wr_en;
    logic                rd_en;
    logic                dual;
    logic                cmp_mode;
    logic                cap_mode;
    logic                hit_main;
    logic                hit_low;
    logic                ev_low_ovf;
    logic                ev_low_cmp;
    logic                ev_capcmp;
    logic [IRQ_BITS-1:0] events;
    logic                oe_bit;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    assign idx      = paddr_i[7:2];
    assign aligned  = (paddr_i[1:0] == 2'b00);
    assign pready_o = 1'b1;
    assign wr_en    = psel_i && penable_i && pwrite_i;
    assign rd_en    = psel_i && penable_i && !pwrite_i;

    always_comb begin
        case (idx)
            IDX_CONTROL_B, IDX_COUNT_VALUE, IDX_RELOAD_VALUE, IDX_CAPCMP_VALUE,
            IDX_CONFIG, IDX_COUNT_HIGH, IDX_RELOAD_HIGH, IDX_CAPCMP_HIGH,
            IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    assign dual     = cfg_ff[CFG_DUAL_BYTE_SELECT];
    assign cmp_mode = !cfg_ff[CFG_COUNTER_SEL] &&
                      (cfg_ff[CFG_EDGE_MSB:CFG_EDGE_LSB] == 2'b00);
    assign cap_mode = !cfg_ff[CFG_COUNTER_SEL] &&
                      (cfg_ff[CFG_EDGE_MSB:CFG_EDGE_LSB] != 2'b00);

    tvr_match u_match (
        .ref_clk_i  (ref_clk_i),
        .resetn_i   (resetn_i),
        .count_i    (count_ff),
        .compare_i  (capcmp_ff),
        .dual_i     (dual),
        .cmp_mode_i (cmp_mode),
        .hit_main_o (hit_main),
        .hit_low_o  (hit_low)
    );

    // ---------------------------------------------------------------
    // events
    // ---------------------------------------------------------------
    assign ev_low_ovf = dual && low_overflow_i;
    assign ev_low_cmp = hit_low;
    assign ev_capcmp  = hit_main || (cap_mode && capture_event_i);

    always_comb begin
        events                   = '0;
        events[IRQ_OVERFLOW]     = overflow_i;
        events[IRQ_LOW_OVERFLOW] = ev_low_ovf;
        events[IRQ_LOW_COMPARE]  = ev_low_cmp;
        events[IRQ_CAPCMP]       = ev_capcmp;
    end

    // ---------------------------------------------------------------
    // count value register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            count_ff <= RST_VALUE16;
        end else if (count_load_i) begin
            count_ff <= count_next_i;
        end else if (wr_en && mapped && idx == IDX_COUNT_VALUE) begin
            if (pstrb_i[0]) begin
                count_ff[7:0] <= pwdata_i[7:0];
            end
            if (pstrb_i[1] && !dual) begin
                count_ff[15:8] <= pwdata_i[15:8];
            end
        end else if (wr_en && mapped && idx == IDX_COUNT_HIGH && pstrb_i[0]) begin
            count_ff[15:8] <= pwdata_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // reload register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reload_ff <= RST_VALUE16;
        end else if (wr_en && mapped && idx == IDX_RELOAD_VALUE) begin
            if (pstrb_i[0]) begin
                reload_ff[7:0] <= pwdata_i[7:0];
            end
            if (pstrb_i[1] && !dual) begin
                reload_ff[15:8] <= pwdata_i[15:8];
            end
        end else if (wr_en && mapped && idx == IDX_RELOAD_HIGH && pstrb_i[0]) begin
            reload_ff[15:8] <= pwdata_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // capture/compare register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            capcmp_ff <= RST_VALUE16;
        end else if (cap_mode && capture_event_i) begin
            // capture in dual mode takes only the high timer byte
            if (dual) begin
                capcmp_ff[15:8] <= count_ff[15:8];
            end else begin
                capcmp_ff <= count_ff;
            end
        end else if (wr_en && mapped && idx == IDX_CAPCMP_VALUE) begin
            if (pstrb_i[0]) begin
                capcmp_ff[7:0] <= pwdata_i[7:0];
            end
            if (pstrb_i[1] && !dual) begin
                capcmp_ff[15:8] <= pwdata_i[15:8];
            end
        end else if (wr_en && mapped && idx == IDX_CAPCMP_HIGH && pstrb_i[0]) begin
            capcmp_ff[15:8] <= pwdata_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cfg_ff <= 4'h0;
        end else if (wr_en && mapped && idx == IDX_CONFIG && pstrb_i[0]) begin
            cfg_ff <= pwdata_i[3:0];
        end
    end

    // ---------------------------------------------------------------
    // control b: software writes, hardware sets win
    // ---------------------------------------------------------------
    generate
        if (TWO_PINS) begin : g_oe
            assign oe_bit = 1'b1;
        end else begin : g_no_oe
            assign oe_bit = 1'b0;
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ctrl_b_ff <= RST_VALUE8;
        end else begin
            if (wr_en && mapped && idx == IDX_CONTROL_B && pstrb_i[0]) begin
                ctrl_b_ff                   <= pwdata_i[7:0];
                ctrl_b_ff[4]                <= 1'b0;
                ctrl_b_ff[CB_SECOND_OE]     <= pwdata_i[CB_SECOND_OE] && oe_bit;
            end
            if (ev_low_cmp) begin
                ctrl_b_ff[CB_LOW_COMPARE_FLAG] <= 1'b1;
            end
            if (ev_capcmp) begin
                ctrl_b_ff[CB_CAPCMP_FLAG] <= 1'b1;
            end
            if (ev_low_ovf) begin
                ctrl_b_ff[CB_LOW_OVERFLOW_FLAG] <= 1'b1;
            end
            if (overflow_i) begin
                ctrl_b_ff[CB_OVERFLOW_FLAG] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, enable, clear
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_en_ff <= RST_IRQ;
        end else if (wr_en && mapped && idx == IDX_IRQ_ENABLE && pstrb_i[0]) begin
            irq_en_ff <= pwdata_i[IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_sts_ff <= RST_IRQ;
        end else if (wr_en && mapped && idx == IDX_IRQ_CLEAR && pstrb_i[0]) begin
            // a new event in the clearing cycle survives
            irq_sts_ff <= (irq_sts_ff & ~pwdata_i[IRQ_BITS-1:0]) | events;
        end else begin
            irq_sts_ff <= irq_sts_ff | events;
        end
    end

    assign irq_o     = |(irq_sts_ff & irq_en_ff);
    assign low_irq_o = ctrl_b_ff[CB_LOW_IRQ_ENABLE] &&
                       (ctrl_b_ff[CB_LOW_OVERFLOW_FLAG] ||
                        ctrl_b_ff[CB_LOW_COMPARE_FLAG]);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (!mapped) begin
            nxt_slverr = 1'b1;
        end else begin
            case (idx)
                IDX_CONTROL_B:    nxt_prdata[7:0] = ctrl_b_ff;
                IDX_COUNT_VALUE:  nxt_prdata[15:0] = {dual ? HIGH_MASKED : count_ff[15:8],
                                                      count_ff[7:0]};
                IDX_RELOAD_VALUE: nxt_prdata[15:0] = {dual ? HIGH_MASKED : reload_ff[15:8],
                                                      reload_ff[7:0]};
                IDX_CAPCMP_VALUE: nxt_prdata[15:0] = {dual ? HIGH_MASKED : capcmp_ff[15:8],
                                                      capcmp_ff[7:0]};
                IDX_CONFIG:       nxt_prdata[3:0] = cfg_ff;
                IDX_COUNT_HIGH:   nxt_prdata[7:0] = count_ff[15:8];
                IDX_RELOAD_HIGH:  nxt_prdata[7:0] = reload_ff[15:8];
                IDX_CAPCMP_HIGH:  nxt_prdata[7:0] = capcmp_ff[15:8];
                IDX_IRQ_STATUS:   nxt_prdata[IRQ_BITS-1:0] = irq_sts_ff;
                IDX_IRQ_ENABLE:   nxt_prdata[IRQ_BITS-1:0] = irq_en_ff;
                default:          nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // read data is registered during setup so it stands in the access phase
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata_o  = rd_en ? prdata_ff : 32'h0000_0000;
    assign pslverr_o = psel_i && penable_i && nxt_slverr;

    // ---------------------------------------------------------------
    // outputs to the counting engine
    // ---------------------------------------------------------------
    assign count_o                = count_ff;
    assign reload_o               = reload_ff;
    assign capcmp_o               = capcmp_ff;
    assign dual_byte_select_o     = dual;
    assign counter_sel_o          = cfg_ff[CFG_COUNTER_SEL];
    assign edge_sel_o             = cfg_ff[CFG_EDGE_MSB:CFG_EDGE_LSB];
    assign polarity1_o            = ctrl_b_ff[CB_POLARITY1];
    assign second_output_enable_o = ctrl_b_ff[CB_SECOND_OE];

endmodule

// >>> tvr_pkg.sv
// package: register map, field positions and reset values of the timer register block
package tvr_pkg;

    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_CONTROL_B      = 6'h0B;
    localparam logic [5:0] IDX_COUNT_VALUE    = 6'h0C;
    localparam logic [5:0] IDX_RELOAD_VALUE   = 6'h0D;
    localparam logic [5:0] IDX_CAPCMP_VALUE   = 6'h0E;
    localparam logic [5:0] IDX_CONFIG         = 6'h0F;
    localparam logic [5:0] IDX_COUNT_HIGH     = 6'h10;
    localparam logic [5:0] IDX_RELOAD_HIGH    = 6'h11;
    localparam logic [5:0] IDX_CAPCMP_HIGH    = 6'h12;
    localparam logic [5:0] IDX_IRQ_STATUS     = 6'h13;
    localparam logic [5:0] IDX_IRQ_ENABLE     = 6'h14;
    localparam logic [5:0] IDX_IRQ_CLEAR      = 6'h15;

    // ---------------------------------------------------------------
    // control b fields
    // ---------------------------------------------------------------
    localparam int CB_LOW_COMPARE_FLAG  = 0;
    localparam int CB_CAPCMP_FLAG       = 1;
    localparam int CB_LOW_OVERFLOW_FLAG = 2;
    localparam int CB_OVERFLOW_FLAG     = 3;
    localparam int CB_POLARITY1         = 5;
    localparam int CB_SECOND_OE         = 6;
    localparam int CB_LOW_IRQ_ENABLE    = 7;

    // ---------------------------------------------------------------
    // config fields
    // ---------------------------------------------------------------
    localparam int CFG_COUNTER_SEL      = 0;
    localparam int CFG_EDGE_LSB         = 1;
    localparam int CFG_EDGE_MSB         = 2;
    localparam int CFG_DUAL_BYTE_SELECT = 3;

    // ---------------------------------------------------------------
    // interrupt status / enable / clear fields
    // ---------------------------------------------------------------
    localparam int IRQ_OVERFLOW         = 0;
    localparam int IRQ_LOW_OVERFLOW     = 1;
    localparam int IRQ_LOW_COMPARE      = 2;
    localparam int IRQ_CAPCMP           = 3;
    localparam int IRQ_BITS             = 4;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_VALUE16 = 16'h0000;
    localparam logic [7:0]  RST_VALUE8  = 8'h00;
    localparam logic [3:0]  RST_IRQ     = 4'h0;
    localparam logic [7:0]  HIGH_MASKED = 8'h00;

endpackage

// >>> tvr_match.sv
// compare unit: one-cycle match pulses for the full/high and low comparisons
`timescale 1ns/1ps
module tvr_match (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] compare_i,
    input  wire logic        dual_i,
    input  wire logic        cmp_mode_i,
    output logic             hit_main_o,
    output logic             hit_low_o
);
    import tvr_pkg::*;

    logic eq_main;
    logic eq_low;
    logic eq_main_ff;
    logic eq_low_ff;

    // ---------------------------------------------------------------
    // equality: 16-bit in single mode, high byte in dual mode
    // ---------------------------------------------------------------
    always_comb begin
        if (dual_i) begin
            eq_main = cmp_mode_i && (count_i[15:8] == compare_i[15:8]);
        end else begin
            eq_main = cmp_mode_i && (count_i == compare_i);
        end
        // low half compares whatever cmp_mode_i is, but only in dual mode
        eq_low = dual_i && (count_i[7:0] == compare_i[7:0]);
    end

    // ---------------------------------------------------------------
    // pulse once when equality begins
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            // start high so an equality present at reset is no match
            eq_main_ff <= 1'b1;
            eq_low_ff  <= 1'b1;
        end else begin
            eq_main_ff <= eq_main;
            eq_low_ff  <= eq_low;
        end
    end

    assign hit_main_o = eq_main && !eq_main_ff;
    assign hit_low_o  = eq_low && !eq_low_ff;

endmodule

// >>> tvr_regs_monitor.sv
// checker: concurrent properties on the timer register block ports
`timescale 1ns/1ps
module tvr_regs_monitor (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        count_load_i,
    input wire logic [15:0] count_next_i,
    input wire logic        low_overflow_i,
    input wire logic        capture_event_i,
    input wire logic [15:0] count_o,
    input wire logic [15:0] reload_o,
    input wire logic [15:0] capcmp_o,
    input wire logic        dual_byte_select_o,
    input wire logic        counter_sel_o,
    input wire logic [1:0]  edge_sel_o,
    input wire logic        low_irq_o
);
    import tvr_pkg::*;
    localparam logic [7:0] A_CB  = {IDX_CONTROL_B, 2'b00};
    localparam logic [7:0] A_CNT = {IDX_COUNT_VALUE, 2'b00};
    localparam logic [7:0] A_RLD = {IDX_RELOAD_VALUE, 2'b00};
    localparam logic [7:0] A_CC  = {IDX_CAPCMP_VALUE, 2'b00};
    logic wr_acc;
    logic rd_acc;
    logic en_ff;
    default clocking mon_cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
    assign rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
    // ---------------------------------------------------------------
    // shadow of the low-half interrupt enable
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            en_ff <= 1'b0;
        end else if (wr_acc && paddr_i == A_CB && pstrb_i[0]) begin
            en_ff <= pwdata_i[CB_LOW_IRQ_ENABLE];
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    reset_clear_a: assert property ($rose(resetn_i) |->
        count_o == 16'h0000 && reload_o == 16'h0000 && capcmp_o == 16'h0000)
        else $error("registers not cleared by reset");
    count_write_a: assert property (wr_acc && paddr_i == A_CNT && pstrb_i == 4'hF
        && !dual_byte_select_o && !count_load_i |=> count_o == $past(pwdata_i[15:0]))
        else $error("count write lost");
    count_load_a: assert property (count_load_i |=> count_o == $past(count_next_i))
        else $error("engine count load lost");
    count_hi_a: assert property (wr_acc && paddr_i == A_CNT && dual_byte_select_o
        && !count_load_i |=> $stable(count_o[15:8]))
        else $error("count upper byte written in dual mode");
    reload_hi_a: assert property (wr_acc && paddr_i == A_RLD && dual_byte_select_o
        |=> $stable(reload_o[15:8]))
        else $error("reload upper byte written in dual mode");
    capcmp_hi_a: assert property (wr_acc && paddr_i == A_CC && dual_byte_select_o
        && !capture_event_i |=> $stable(capcmp_o[15:8]))
        else $error("capcmp upper byte written in dual mode");
    read_mask_a: assert property (rd_acc && dual_byte_select_o
        && (paddr_i == A_CNT || paddr_i == A_RLD || paddr_i == A_CC) |-> prdata_o[31:8] == 24'h0)
        else $error("upper byte not masked in dual mode");
    capture_load_a: assert property (capture_event_i && !dual_byte_select_o && !counter_sel_o
        && edge_sel_o != 2'b00 && !(wr_acc && paddr_i == A_CC) |=> capcmp_o == $past(count_o))
        else $error("capture did not load count");
    low_mask_a: assert property (!en_ff |-> !low_irq_o)
        else $error("low irq while disabled");
    low_raise_a: assert property (en_ff && low_overflow_i && dual_byte_select_o
        && !(wr_acc && paddr_i == A_CB) |=> low_irq_o)
        else $error("low irq not raised");
    unmapped_a: assert property (rd_acc && paddr_i == 8'h00 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped read not refused");
    cover property (capture_event_i && !dual_byte_select_o);
    cover property (low_irq_o);
    cover property (wr_acc && dual_byte_select_o && paddr_i == A_CNT);
endmodule

// >>> tvr_regs_tb_top.sv
// testbench: apb access, dual byte masking, capture, compare and interrupts
`timescale 1ns/1ps
module tvr_regs_tb_top;
    import tvr_pkg::*;
    localparam logic [7:0] A_CB  = {IDX_CONTROL_B, 2'b00};
    localparam logic [7:0] A_CFG = {IDX_CONFIG, 2'b00};
    localparam logic [7:0] A_ST  = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_EN  = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [7:0] A_CLR = {IDX_IRQ_CLEAR, 2'b00};
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        count_load = 1'b0, ovf = 1'b0, low_ovf = 1'b0, capt = 1'b0;
    logic [15:0] count_next = 16'h0000;
    logic [31:0] prdata, d;
    logic        pready, pslverr, last_err, dual, csel, pol1, oe2, low_irq, irq;
    logic [15:0] count, reload, capcmp;
    logic [1:0]  edge_sel;
    logic [7:0]  va [3];
    logic [7:0]  ha [3];
    int          fails = 0;
    int          check_count = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    tvr_regs dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .count_load_i(count_load), .count_next_i(count_next), .overflow_i(ovf),
        .low_overflow_i(low_ovf), .capture_event_i(capt), .count_o(count), .reload_o(reload),
        .capcmp_o(capcmp), .dual_byte_select_o(dual), .counter_sel_o(csel),
        .edge_sel_o(edge_sel), .polarity1_o(pol1), .second_output_enable_o(oe2),
        .low_irq_o(low_irq), .irq_o(irq));
    // ---------------------------------------------------------------
    // bus, stimulus and compare tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= 4'hF;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        d = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the access settle before outputs are compared
        @(posedge ref_clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        if (k == 0) ovf <= 1'b1;
        else if (k == 1) low_ovf <= 1'b1;
        else capt <= 1'b1;
        @(posedge ref_clk_i);
        {ovf, low_ovf, capt} <= 3'b000;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge ref_clk_i);
        count_next <= v;
        count_load <= 1'b1;
        @(posedge ref_clk_i);
        count_load <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        va = '{{IDX_COUNT_VALUE, 2'b00}, {IDX_RELOAD_VALUE, 2'b00}, {IDX_CAPCMP_VALUE, 2'b00}};
        ha = '{{IDX_COUNT_HIGH, 2'b00}, {IDX_RELOAD_HIGH, 2'b00}, {IDX_CAPCMP_HIGH, 2'b00}};
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(0, va[i], 0);
            chk(d, 32'h0);
            apb(1, va[i], 32'hA5C0 + i);
            apb(0, va[i], 0);
            chk(d, 32'hA5C0 + i);
        end
        chk({16'h0, capcmp}, 32'hA5C2);
        apb(1, A_CFG, 32'h8);
        chk({31'h0, dual}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1, va[i], 32'h1234);
            apb(0, va[i], 0);
            chk(d, 32'h34);
            apb(0, ha[i], 0);
            chk(d, 32'hA5);
            apb(1, ha[i], 32'h77);
            apb(0, ha[i], 0);
            chk(d, 32'h77);
        end
        apb(1, A_CFG, 32'h2);
        chk({29'h0, csel, edge_sel}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(0, va[i], 0);
            chk(d, 32'h7734);
        end
        apb(1, va[0], 32'h5A3C);
        apb(1, A_CB, 32'h0);
        pulse(2);
        apb(0, va[2], 0);
        chk(d, 32'h5A3C);
        apb(0, A_CB, 0);
        chk(d & 32'h2, 32'h2);
        apb(1, A_CFG, 32'h0);
        apb(1, A_CB, 32'h0);
        apb(1, va[2], 32'h0100);
        apb(0, A_CB, 0);
        chk(d & 32'h2, 32'h0);
        load(16'h0100);
        apb(0, A_CB, 0);
        chk(d & 32'h2, 32'h2);
        pulse(1);
        apb(0, A_CB, 0);
        chk(d & 32'h4, 32'h0);
        apb(1, A_CFG, 32'h8);
        apb(1, A_CB, 32'h0);
        pulse(1);
        apb(0, A_CB, 0);
        chk(d & 32'h4, 32'h4);
        chk({31'h0, low_irq}, 32'h0);
        apb(1, A_CB, 32'h80);
        chk({31'h0, low_irq}, 32'h0);
        pulse(1);
        chk({31'h0, low_irq}, 32'h1);
        apb(1, A_CB, 32'h80);
        apb(1, va[2], 32'h0042);
        load(16'h0042);
        apb(0, A_CB, 0);
        chk(d & 32'h1, 32'h1);
        chk({31'h0, low_irq}, 32'h1);
        apb(1, A_CB, 32'h01);
        chk({31'h0, low_irq}, 32'h0);
        apb(1, A_CB, 32'h60);
        chk({30'h0, oe2, pol1}, 32'h3);
        apb(1, A_CLR, 32'hF);
        apb(1, A_EN, 32'h1);
        pulse(0);
        chk({31'h0, irq}, 32'h1);
        apb(1, A_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1, A_ST, 32'h0);
        apb(0, A_ST, 0);
        chk(d, 32'h1);
        apb(1, A_CLR, 32'h1);
        apb(0, A_ST, 0);
        chk(d, 32'h0);
        apb(0, 8'h00, 0);
        chk({last_err, d[30:0]}, 32'h80000000);
        apb(1, va[0], 32'h1111);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(0, va[i], 0);
            chk(d, 32'h0);
        end
        chk({31'h0, dual}, 32'h0);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        conclude();
    end
endmodule
bind tvr_regs tvr_regs_monitor mon_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .count_load_i(count_load_i), .count_next_i(count_next_i),
    .low_overflow_i(low_overflow_i), .capture_event_i(capture_event_i), .count_o(count_o),
    .reload_o(reload_o), .capcmp_o(capcmp_o), .dual_byte_select_o(dual_byte_select_o),
    .counter_sel_o(counter_sel_o), .edge_sel_o(edge_sel_o), .low_irq_o(low_irq_o));
